// ---- poweron_straps_pkg.sv ----
// poweron_straps_pkg: offsets, field positions and reset values shared by
// the strap latch. assumes a 32-bit classic wishbone register bus.
package poweron_straps_pkg;

  // register byte offsets
  localparam logic [3:0] STATUS_OFFSET       = 4'h0;
  localparam logic [3:0] CORE_DISABLE_OFFSET = 4'h4;
  localparam logic [3:0] LATCH_COUNT_OFFSET  = 4'h8;

  // status field positions
  localparam int BIT_RESILIENT   = 0;
  localparam int BIT_SELF_TEST   = 1;
  localparam int BIT_SERVICE     = 2;
  localparam int BIT_TRUSTED_PLT = 3;
  localparam int BIT_HALT        = 4;
  localparam int BIT_FIRMWARE    = 5;
  localparam int BIT_TRUSTED_AGT = 6;
  localparam int BIT_SAFE_MODE   = 7;
  localparam int BIT_SLOT_LO     = 8;
  localparam int BIT_EARLY_VALID = 16;
  localparam int BIT_LATE_VALID  = 17;
  localparam int BIT_POWER_OK    = 18;

  // values after reset
  localparam logic [31:0] CORE_DISABLE_RESET = 32'h0000_0000;
  localparam logic [7:0]  LATCH_COUNT_RESET  = 8'h00;

  // cycles after reset release before the synchronised straps are trusted
  localparam logic [1:0]  ARM_CYCLES = 2'h3;

endpackage

// ---- strap_sync.sv ----
// strap_sync: two-flop synchroniser for a bundle of slow board levels.
// assumes each bit is a quasi-static level; no word coherence is promised.
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;

  // no reset: these carry data only, and the consumer waits for them to fill
  always_ff @(posedge clk_i) begin
    meta   <= d_i;
    stable <= meta;
  end

  assign q_o = stable;

endmodule

// ---- poweron_strap_latch_frb.sv ----
// poweron_strap_latch_frb: power-on strap capture, socket-level resilient
// boot output floating and per-core disable register.
// assumes straps are board levels that settle before reset release or
// before power good rises; registers sit on a classic wishbone slave.
//
// Notes on behaviour
// RL1: capture strap levels on reset release or power good rising.
// RL2: captured values hold until the next latching transition.
// RL3: thermal alarm held low through reset release enters resilient boot.
// RL4: self-test strap sampled at reset release; set means run self test.
// RL5: all other straps sampled once power good is asserted.
// RL6: decode service boot, trusted, halt, firmware, agent, safe, slot.
// RL7: resilient boot floats link, serial, sideband and voltage clock drivers.
// RL8: register lets software disable individual cores, not the package.
// RL9: options are registered stable outputs; straps synchronised first.
`timescale 1ns/1ps
module poweron_strap_latch_frb
  import poweron_straps_pkg::*;
#(
  parameter int CORE_COUNT = 8,
  parameter int ADDR_W     = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // board straps and power good
  input  wire logic              power_ok_in_i,
  input  wire logic              thermal_alarm_strap_n_i,
  input  wire logic              self_test_strap_i,
  input  wire logic              service_proc_boot_strap_i,
  input  wire logic              trusted_platform_strap_i,
  input  wire logic              powerup_halt_strap_n_i,
  input  wire logic              firmware_agent_strap_i,
  input  wire logic              trusted_agent_strap_i,
  input  wire logic              safe_mode_boot_strap_i,
  input  wire logic [1:0]        package_slot_number_i,
  // captured options
  output logic                   resilient_boot_mode_o,
  output logic                   self_test_run_o,
  output logic                   service_proc_boot_o,
  output logic                   trusted_platform_o,
  output logic                   powerup_halt_o,
  output logic                   firmware_agent_o,
  output logic                   trusted_agent_o,
  output logic                   safe_mode_boot_o,
  output logic [1:0]             package_slot_number_o,
  output logic                   straps_valid_o,
  // driver enables of floated groups, high while allowed to drive
  output logic                   link_tx_drive_en_o,
  output logic                   mgmt_serial_drive_en_o,
  output logic                   sideband_drive_en_o,
  output logic                   voltage_ctrl_clock_drive_en_o,
  output logic [CORE_COUNT-1:0]  core_disable_o,
  // classic wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o
);

  //////////////////////////////////////////////////////////////////////////
  // synchronisers

  localparam int SYNC_W = 11;

  logic [SYNC_W-1:0] raw_straps;
  logic [SYNC_W-1:0] sync_straps;

  assign raw_straps = {power_ok_in_i, thermal_alarm_strap_n_i,
                       self_test_strap_i, service_proc_boot_strap_i,
                       trusted_platform_strap_i, powerup_halt_strap_n_i,
                       firmware_agent_strap_i, trusted_agent_strap_i,
                       safe_mode_boot_strap_i, package_slot_number_i};

  strap_sync #(
    .WIDTH (SYNC_W)
  ) u_strap_sync (
    .clk_i (clk_i),
    .d_i   (raw_straps),
    .q_o   (sync_straps)
  ); // RL9

  logic       s_power_ok;
  logic       s_thermal_n;
  logic       s_self_test;
  logic       s_service;
  logic       s_trusted_plt;
  logic       s_halt_n;
  logic       s_firmware;
  logic       s_trusted_agt;
  logic       s_safe;
  logic [1:0] s_slot;

  assign {s_power_ok, s_thermal_n, s_self_test, s_service, s_trusted_plt,
          s_halt_n, s_firmware, s_trusted_agt, s_safe, s_slot} = sync_straps;

  //////////////////////////////////////////////////////////////////////////
  // capture sequencing

  logic [1:0] arm_cnt;
  logic [1:0] next_arm_cnt;
  logic       armed;
  logic       next_armed;
  logic       power_ok_d;
  logic       next_power_ok_d;
  logic       early_take;
  logic       late_take;

  // synchroniser has no reset, so wait for it to refill after release
  always_comb begin
    next_arm_cnt    = arm_cnt;
    next_armed      = armed;
    next_power_ok_d = s_power_ok;
    if (!armed) begin
      if (arm_cnt == ARM_CYCLES) begin
        next_armed = 1'b1;
      end else begin
        next_arm_cnt = arm_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arm_cnt    <= 2'h0;
      armed      <= 1'b0;
      power_ok_d <= 1'b0;
    end else begin
      arm_cnt    <= next_arm_cnt;
      armed      <= next_armed;
      power_ok_d <= next_power_ok_d;
    end
  end

  // reset release counts once the synchronised levels are valid
  assign early_take = !armed && (arm_cnt == ARM_CYCLES); // RL1
  // power good already high at release also counts as asserted
  assign late_take  = (early_take && s_power_ok) ||
                      (armed && s_power_ok && !power_ok_d); // RL1 RL5

  //////////////////////////////////////////////////////////////////////////
  // captured options

  logic       rb_mode;
  logic       next_rb_mode;
  logic       self_test;
  logic       next_self_test;
  logic [7:0] late_opts;
  logic [7:0] next_late_opts;
  logic       early_valid;
  logic       next_early_valid;
  logic       late_valid;
  logic       next_late_valid;
  logic [7:0] latch_count;
  logic [7:0] next_latch_count;

  always_comb begin
    next_rb_mode     = rb_mode; // RL2
    next_self_test   = self_test;
    next_late_opts   = late_opts;
    next_early_valid = early_valid;
    next_late_valid  = late_valid;
    next_latch_count = latch_count;
    if (early_take) begin
      next_rb_mode     = !s_thermal_n; // RL3
      next_self_test   = s_self_test; // RL4
      next_early_valid = 1'b1;
    end
    if (late_take) begin
      // halt strap is active low on the board, presented active high
      next_late_opts  = {s_slot, s_safe, s_trusted_agt, s_firmware,
                         !s_halt_n, s_trusted_plt, s_service}; // RL5 RL6
      next_late_valid = 1'b1;
    end
    if (early_take || late_take) begin
      next_latch_count = latch_count + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rb_mode     <= 1'b0;
      self_test   <= 1'b0;
      late_opts   <= 8'h00;
      early_valid <= 1'b0;
      late_valid  <= 1'b0;
      latch_count <= LATCH_COUNT_RESET;
    end else begin
      rb_mode     <= next_rb_mode;
      self_test   <= next_self_test;
      late_opts   <= next_late_opts;
      early_valid <= next_early_valid;
      late_valid  <= next_late_valid;
      latch_count <= next_latch_count;
    end
  end

  // direct flop outputs
  assign resilient_boot_mode_o = rb_mode; // RL9
  assign self_test_run_o       = self_test; // RL4
  assign service_proc_boot_o   = late_opts[0];
  assign trusted_platform_o    = late_opts[1];
  assign powerup_halt_o        = late_opts[2];
  assign firmware_agent_o      = late_opts[3];
  assign trusted_agent_o       = late_opts[4];
  assign safe_mode_boot_o      = late_opts[5];
  assign package_slot_number_o = late_opts[7:6];

  //////////////////////////////////////////////////////////////////////////
  // driver enables

  logic drive_en;
  logic next_drive_en;
  logic valid_q;
  logic next_valid_q;

  // drivers stay released from reset until the alarm strap is known,
  // so a socket meant to float never glitches onto the shared lines
  always_comb begin
    next_drive_en = next_early_valid && !next_rb_mode; // RL7
    next_valid_q  = next_early_valid && next_late_valid;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drive_en <= 1'b0;
      valid_q  <= 1'b0;
    end else begin
      drive_en <= next_drive_en;
      valid_q  <= next_valid_q;
    end
  end

  assign link_tx_drive_en_o            = drive_en; // RL7
  assign mgmt_serial_drive_en_o        = drive_en; // RL7
  assign sideband_drive_en_o           = drive_en; // RL7
  assign voltage_ctrl_clock_drive_en_o = drive_en; // RL7
  assign straps_valid_o                = valid_q;

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic [31:0]           status_word;
  logic [CORE_COUNT-1:0] core_dis;
  logic [CORE_COUNT-1:0] next_core_dis;
  logic [31:0]           core_dis_wide;
  logic [31:0]           core_dis_new;
  logic                  ack;
  logic                  next_ack;
  logic [31:0]           rdata;
  logic [31:0]           next_rdata;
  logic [3:0]            word_adr;
  logic                  req;

  assign req      = wb_cyc_i && wb_stb_i && !ack;
  assign word_adr = {wb_adr_i[3:2], 2'h0};

  always_comb begin
    status_word                  = 32'h0000_0000;
    status_word[BIT_RESILIENT]   = rb_mode;
    status_word[BIT_SELF_TEST]   = self_test;
    status_word[BIT_SERVICE]     = late_opts[0];
    status_word[BIT_TRUSTED_PLT] = late_opts[1];
    status_word[BIT_HALT]        = late_opts[2];
    status_word[BIT_FIRMWARE]    = late_opts[3];
    status_word[BIT_TRUSTED_AGT] = late_opts[4];
    status_word[BIT_SAFE_MODE]   = late_opts[5];
    status_word[BIT_SLOT_LO+1:BIT_SLOT_LO] = late_opts[7:6];
    status_word[BIT_EARLY_VALID] = early_valid;
    status_word[BIT_LATE_VALID]  = late_valid;
    status_word[BIT_POWER_OK]    = s_power_ok;
  end

  always_comb begin
    core_dis_wide = 32'h0000_0000;
    core_dis_wide[CORE_COUNT-1:0] = core_dis;
    for (int b = 0; b < 4; b++) begin
      core_dis_new[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8]
                                           : core_dis_wide[8*b +: 8];
    end
  end

  // one wait-free cycle: ack the edge after the request, drop it the next
  always_comb begin
    next_ack      = req;
    next_rdata    = rdata;
    next_core_dis = core_dis;
    if (req) begin
      next_rdata = 32'h0000_0000;
      if (wb_we_i) begin
        if (word_adr == CORE_DISABLE_OFFSET) begin
          next_core_dis = core_dis_new[CORE_COUNT-1:0]; // RL8
        end
      end else begin
        case (word_adr)
          STATUS_OFFSET:       next_rdata = status_word;
          CORE_DISABLE_OFFSET: next_rdata = core_dis_wide;
          LATCH_COUNT_OFFSET:  next_rdata = {24'h00_0000, latch_count};
          default:             next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack      <= 1'b0;
      rdata    <= 32'h0000_0000;
      core_dis <= CORE_DISABLE_RESET[CORE_COUNT-1:0];
    end else begin
      ack      <= next_ack;
      rdata    <= next_rdata;
      core_dis <= next_core_dis;
    end
  end

  assign wb_ack_o       = ack;
  assign wb_dat_o       = rdata;
  assign core_disable_o = core_dis; // RL8

endmodule

// ---- poweron_straps_pkg_unused_guard.sv ----
// poweron_straps_pkg_unused_guard: intentionally empty compilation unit.
// assumes nothing.

// ---- strap_board.sv ----
// strap_board: board straps and power good source for the latch.
// assumes the bench picks the pattern; bits 0 and 4 are active low pins.
`timescale 1ns/1ps
module strap_board (
  input  wire logic       clk_i,
  input  wire logic [9:0] pattern_i,
  input  wire logic       pg_i,
  output logic      [9:0] straps_o = 10'h011,
  output logic            power_ok_o = 1'h0
);
  // pins move only after an edge, like slow board levels
  always_ff @(posedge clk_i) begin
    straps_o   <= pattern_i ^ 10'h011;
    power_ok_o <= pg_i;
  end
endmodule

// ---- strap_latch_props.sv ----
// strap_latch_props: port checks for the strap latch.
// assumes one clock and the synchronous active low reset.
`timescale 1ns/1ps
module strap_latch_props
  import poweron_straps_pkg::*;
#(
  parameter int CORE_COUNT = 8,
  parameter int ADDR_W     = 4
) (
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  power_ok_in_i,
  input wire logic                  resilient_boot_mode_o,
  input wire logic [1:0]            package_slot_number_o,
  input wire logic                  straps_valid_o,
  input wire logic                  link_tx_drive_en_o,
  input wire logic                  mgmt_serial_drive_en_o,
  input wire logic                  sideband_drive_en_o,
  input wire logic                  voltage_ctrl_clock_drive_en_o,
  input wire logic [CORE_COUNT-1:0] core_disable_o,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [ADDR_W-1:0]     wb_adr_i,
  input wire logic [3:0]            wb_sel_i,
  input wire logic [31:0]           wb_dat_i,
  input wire logic                  wb_ack_o
);
  // cycles since release, saturating; release captures are over by 7
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [6:0] pg_hist;
  always_comb next_cnt = (cnt == 3'h7) ? cnt : cnt + 3'h1;
  always_ff @(posedge clk_i) begin
    cnt     <= rst_n_i ? next_cnt : 3'h0;
    pg_hist <= {pg_hist[5:0], power_ok_in_i};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cd_wr;
    s_take ##0 (wb_we_i && wb_sel_i == 4'hF
      && wb_adr_i == CORE_DISABLE_OFFSET);
  endsequence
  chk_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_core_write: assert property (s_cd_wr |=>
    core_disable_o == $past(wb_dat_i[CORE_COUNT-1:0]))
    else $error("core disable not written");
  chk_float_groups: assert property (
    resilient_boot_mode_o |-> !(link_tx_drive_en_o
    || mgmt_serial_drive_en_o || sideband_drive_en_o
    || voltage_ctrl_clock_drive_en_o))
    else $error("driver enabled in resilient boot");
  chk_groups_agree: assert property (
    {mgmt_serial_drive_en_o, sideband_drive_en_o,
    voltage_ctrl_clock_drive_en_o} == {3{link_tx_drive_en_o}})
    else $error("drive enables differ");
  chk_early_hold: assert property (
    cnt == 3'h7 |-> $stable(resilient_boot_mode_o))
    else $error("early option changed");
  chk_late_hold: assert property (
    cnt == 3'h7 && $changed(package_slot_number_o)
    |-> |(pg_hist[5:0] & ~pg_hist[6:1]))
    else $error("late option changed without power good");
  chk_post_reset: assert property (cnt == 3'h1 |->
    !straps_valid_o && !link_tx_drive_en_o && ~|core_disable_o)
    else $error("outputs set right after reset");
endmodule

bind poweron_strap_latch_frb strap_latch_props #(
  .CORE_COUNT(CORE_COUNT), .ADDR_W(ADDR_W)) u_props (
  .clk_i, .rst_n_i, .power_ok_in_i, .resilient_boot_mode_o,
  .package_slot_number_o, .straps_valid_o, .link_tx_drive_en_o,
  .mgmt_serial_drive_en_o, .sideband_drive_en_o,
  .voltage_ctrl_clock_drive_en_o, .core_disable_o, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o);

// ---- tb_top.sv ----
// tb_top: self-checking bench for the strap latch.
// assumes strap_board drives the pins and the bench the wishbone master.
`timescale 1ns/1ps
module tb_top;
  import poweron_straps_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        pg = 1'h0;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [9:0]  pat = 10'h000;
  logic [9:0]  pin;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic [1:0]  slot;
  logic [7:0]  cd;
  logic        pok, ack, res, st, sp, tp, ph, fa, ta, sm, vld;
  logic        e0, e1, e2, e3;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #50 clk_i = ~clk_i;
  strap_board u_board (.clk_i(clk_i), .pattern_i(pat), .pg_i(pg),
    .straps_o(pin), .power_ok_o(pok));
  poweron_strap_latch_frb uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .power_ok_in_i(pok), .thermal_alarm_strap_n_i(pin[0]),
    .self_test_strap_i(pin[1]), .service_proc_boot_strap_i(pin[2]),
    .trusted_platform_strap_i(pin[3]), .powerup_halt_strap_n_i(pin[4]),
    .firmware_agent_strap_i(pin[5]), .trusted_agent_strap_i(pin[6]),
    .safe_mode_boot_strap_i(pin[7]), .package_slot_number_i(pin[9:8]),
    .resilient_boot_mode_o(res), .self_test_run_o(st),
    .service_proc_boot_o(sp), .trusted_platform_o(tp),
    .powerup_halt_o(ph), .firmware_agent_o(fa), .trusted_agent_o(ta),
    .safe_mode_boot_o(sm), .package_slot_number_o(slot),
    .straps_valid_o(vld), .link_tx_drive_en_o(e0),
    .mgmt_serial_drive_en_o(e1), .sideband_drive_en_o(e2),
    .voltage_ctrl_clock_drive_en_o(e3), .core_disable_o(cd),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  //////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, s,
                     input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 50);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 50) check("ack", 32'h0, 32'h1);
  endtask
  function automatic logic [31:0] opts();
    return {22'h0, slot, sm, ta, fa, ph, tp, sp, st, res};
  endfunction
  //////////////////////////////////////////////////////////////
  // power good either high through release or rising well after it
  task automatic t_boot(input logic [9:0] p, input logic pg_early);
    @(posedge clk_i);
    pat     <= p;
    pg      <= pg_early;
    rst_n_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    check("in_reset", {22'h0, vld, e0, cd}, 32'h0);
    rst_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    pg <= 1'h1;
    repeat (8) @(posedge clk_i);
    check("options", opts(), {22'h0, p});
    check("valid", {31'h0, vld}, 32'h1);
    check("drive_en", {28'h0, e0, e1, e2, e3}, {28'h0, {4{~p[0]}}});
    bus(1'h0, STATUS_OFFSET, 4'hF, 32'h0, rd);
    check("status", rd, {13'h0, 3'h7, 6'h0, p});
  endtask
  task automatic t_hold(input logic [9:0] p);
    t_boot(p, 1'h1);
    pat <= ~p;
    repeat (10) @(posedge clk_i);
    check("held", opts(), {22'h0, p});
    pg <= 1'h0;
    repeat (6) @(posedge clk_i);
    pg <= 1'h1;
    repeat (8) @(posedge clk_i);
    check("late", opts(), {22'h0, ~p[9:2], p[1:0]});
  endtask
  task automatic t_core;
    bus(1'h0, CORE_DISABLE_OFFSET, 4'hF, 32'h0, rd);
    check("cd_reset", rd, CORE_DISABLE_RESET);
    bus(1'h1, CORE_DISABLE_OFFSET, 4'hF, 32'hFFFF_FFA5, rd);
    @(posedge clk_i);
    check("cd_out", {24'h0, cd}, 32'h0000_00A5);
    bus(1'h1, CORE_DISABLE_OFFSET, 4'h0, 32'h0000_00FF, rd);
    bus(1'h1, STATUS_OFFSET, 4'hF, 32'hFFFF_FFFF, rd);
    bus(1'h0, CORE_DISABLE_OFFSET, 4'hF, 32'h0, rd);
    check("cd_read", rd, 32'h0000_00A5);
    bus(1'h0, 4'hC, 4'hF, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // release capture with power good high counts once, then one late rise
    bus(1'h0, LATCH_COUNT_OFFSET, 4'hF, 32'h0, rd);
    check("latch_count", rd, 32'h0000_0002);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    t_boot(10'h3FF, 1'h0);
    t_boot(10'h000, 1'h1);
    t_boot(10'h2AA, 1'h0);
    t_boot(10'h155, 1'h1);
    t_hold(10'h2B6);
    t_core;
    t_boot(10'h0C3, 1'h1);
    end_sim;
  end
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    end_sim;
  end
endmodule
